// >>> logic/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// ----------------------------------------------------------------
// Register file geometry
// ----------------------------------------------------------------
`define CRS_NREG 32
`define CRS_WORD_W 32
`define CRS_IDX_W 5
`define CRS_NLANE 4
`define CRS_ZERO_INT 5'h00
`define CRS_ZERO_FLT_HI 5'h01

// ----------------------------------------------------------------
// Floating-point access sizes
// ----------------------------------------------------------------
`define CRS_FSZ_32 2'h0
`define CRS_FSZ_64 2'h1
`define CRS_FSZ_128 2'h2

// ----------------------------------------------------------------
// Processor state field positions
// ----------------------------------------------------------------
`define CRS_PSR_BR 0
`define CRS_PSR_BW 1
`define CRS_PSR_CC 2
`define CRS_PSR_LCC 3
`define CRS_PSR_IM 4
`define CRS_PSR_PIM 5
`define CRS_PSR_U 6
`define CRS_PSR_PU 7
`define CRS_PSR_IT 8
`define CRS_PSR_IN 9
`define CRS_PSR_IAT 10
`define CRS_PSR_DAT 11
`define CRS_PSR_FT 12
`define CRS_PSR_DS 13
`define CRS_PSR_DIM 14
`define CRS_PSR_KNF 15
`define CRS_PSR_SC_LO 17
`define CRS_PSR_SC_HI 21
`define CRS_PSR_PS_LO 22
`define CRS_PSR_PS_HI 23
`define CRS_PSR_PM_LO 24
`define CRS_PSR_PM_HI 31
`define CRS_PSR_RST 32'h00000000
`define CRS_PSR_USER_MASK 32'hfffe000c
`define CRS_PSR_RSVD_MASK 32'hfffeffff

// ----------------------------------------------------------------
// Control register selects and watch compare
// ----------------------------------------------------------------
`define CRS_CSEL_PSR 3'h0
`define CRS_CSEL_EPSR 3'h1
`define CRS_CSEL_DB 3'h2
`define CRS_CSEL_DIRBASE 3'h3
`define CRS_CSEL_FIR 3'h4
`define CRS_CSEL_FSR 3'h5
`define CRS_DB_RST 32'h00000000
`define CRS_ADDR_ONES 32'hffffffff

// ----------------------------------------------------------------
// Pixel formats
// ----------------------------------------------------------------
`define CRS_PS_8 2'h0
`define CRS_PS_16 2'h1
`define CRS_PS_32 2'h2
`define CRS_BYTE_W 8
`define CRS_HALF_W 16
`define CRS_F16_B 6
`define CRS_F16_C 12
`define CRS_NBYTE 8

`endif

// >>> logic/crs_pkg.sv
`include "crs_defines.svh"

package crs_pkg;

  // ----------------------------------------------------------------
  // Port carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [`CRS_IDX_W-1:0] addr;
    logic [`CRS_WORD_W-1:0] data;
  } crs_iwr_s;

  typedef struct packed {
    logic en;
    logic [1:0] size;
    logic [`CRS_IDX_W-1:0] addr;
    logic [`CRS_NLANE*`CRS_WORD_W-1:0] data;
  } crs_fwr_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] sel;
    logic [`CRS_WORD_W-1:0] data;
  } crs_ctrl_s;

  typedef struct packed {
    logic fp;
    logic fetch;
    logic opcode;
    logic dual_active;
    logic before_switch;
  } crs_trap_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [`CRS_WORD_W-1:0] addr;
  } crs_dacc_s;

  typedef struct packed {
    logic valid;
    logic dual_bit;
  } crs_fpiss_s;

  typedef struct packed {
    logic valid;
    logic [`CRS_PSR_SC_HI-`CRS_PSR_SC_LO:0] count;
  } crs_shr_s;

  typedef struct packed {
    logic valid;
    logic value;
  } crs_flag_s;

  typedef enum logic {MODE_RUN, MODE_PEND} crs_mode_e;

endpackage

// >>> logic/crs_pixel_unit.sv
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_pixel_unit (
  input wire logic [1:0] ps,
  input wire logic [`CRS_NBYTE-1:0] pm,
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  output logic [63:0] sum,
  output logic [`CRS_NBYTE-1:0] byte_en
);
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // Field heads
  // ----------------------------------------------------------------
  function automatic logic field_head(input logic [1:0] sz, input int i);
    int h;
    h = i % `CRS_HALF_W;
    case (sz)
      `CRS_PS_16: field_head = (h == 0) || (h == `CRS_F16_B) ||
                               (h == `CRS_F16_C);
      default: field_head = (i % `CRS_BYTE_W) == 0;
    endcase
  endfunction

  logic [63:0] carry;
  logic [63:0] cin;

  genvar i;
  generate
    for (i = 0; i < 64; i++) begin : g_bit
      if (i == 0) begin : g_first
        assign cin[i] = 1'b0;
      end else begin : g_rest
        assign cin[i] = field_head(ps, i) ? 1'b0 : carry[i-1];
      end
      assign sum[i] = a[i] ^ b[i] ^ cin[i];
      assign carry[i] = (a[i] & b[i]) | (cin[i] & (a[i] ^ b[i]));
    end
  endgenerate

  genvar j;
  generate
    for (j = 0; j < `CRS_NBYTE; j++) begin : g_byte
      assign byte_en[j] = (ps == `CRS_PS_8) ? pm[j] :
                          (ps == `CRS_PS_16) ? pm[j/2] :
                          (ps == `CRS_PS_32) ? pm[j/4] : 1'b0;
    end
  endgenerate

endmodule

// >>> logic/crs_regset.sv
// Function
// - 8-bit pixel: whole byte is one field, intensity in low bits.
// - 16-bit pixels split 6/6/4, 32-bit pixels into four bytes.
// - Control registers reached only through control load/store port.
// - 32 integer registers of 32 bits; register zero reads zero.
// - 32 float registers of 32 bits; registers zero and one read zero.
// - 64-bit uses even/odd pair, 128-bit aligned quad, lowest number.
// - Lowest register holds least significant part of wide values.
// - Read and write watch enables trap on operand address hit.
// - External interrupts accepted only while interrupt allow is set.
// - Privilege bit set in user mode blocks some control writes.
// - Trap saves allow and privilege; flagged return restores them.
// - Separate sticky flags for each trap cause.
// - Deferred switch flips issue mode one instruction after return.
// - Trap records dual state; return resumes dual if it is set.
// - Kill-next suppresses next float op but keeps its dual bit.
// - Shift amount captures last right shift count.
// - Width code 00/01/10 selects 8/16/32-bit pixels.
// - Pixel store writes pixels whose select bit is set.
// - Tests set condition flag; loop branch tests and sets its own.
// - Double value: bits 31..0 even register, 63..32 odd register.
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_regset (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic [`CRS_IDX_W-1:0] INT_RA,
  input wire logic [`CRS_IDX_W-1:0] INT_RB,
  input wire crs_pkg::crs_iwr_s INT_WR,
  output logic [`CRS_WORD_W-1:0] INT_RDA,
  output logic [`CRS_WORD_W-1:0] INT_RDB,
  input wire logic [`CRS_IDX_W-1:0] FP_RA,
  input wire logic [1:0] FP_RSIZE,
  input wire crs_pkg::crs_fwr_s FP_WR,
  output logic [`CRS_NLANE*`CRS_WORD_W-1:0] FP_RD,
  input wire crs_pkg::crs_ctrl_s CTRL,
  output logic [`CRS_WORD_W-1:0] CTRL_RDATA,
  output logic CTRL_ACK,
  input wire crs_pkg::crs_trap_s TRAP_IN,
  input wire logic EXT_IRQ,
  input wire crs_pkg::crs_dacc_s DATA_ACC,
  input wire logic RET_IND,
  input wire logic INSTR_DONE,
  input wire crs_pkg::crs_fpiss_s FP_ISSUE,
  output logic FP_KILL,
  output logic FP_DUAL_BIT,
  input wire crs_pkg::crs_shr_s SHR_EV,
  input wire crs_pkg::crs_flag_s COND_WR,
  input wire crs_pkg::crs_flag_s LOOP_BR,
  output logic LOOP_TAKEN,
  input wire logic [63:0] PIX_A,
  input wire logic [63:0] PIX_B,
  output logic [63:0] PIX_SUM,
  output logic [`CRS_NBYTE-1:0] PST_BYTE_EN,
  output logic [`CRS_WORD_W-1:0] PSR_OUT,
  output logic DUAL_MODE,
  output logic TRAP_TAKEN
);
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  logic [`CRS_WORD_W-1:0] int_mem [`CRS_NREG];
  logic [`CRS_WORD_W-1:0] fp_mem [`CRS_NREG];

  function automatic logic [`CRS_WORD_W-1:0] int_read(
      input logic [`CRS_IDX_W-1:0] idx);
    int_read = (idx == `CRS_ZERO_INT) ? '0 : int_mem[idx];
  endfunction

  function automatic logic [`CRS_WORD_W-1:0] fp_read(
      input logic [`CRS_IDX_W-1:0] idx);
    fp_read = (idx <= `CRS_ZERO_FLT_HI) ? '0 : fp_mem[idx];
  endfunction

  // Misaligned numbers are undefined; dropping low bits is the cheap answer
  function automatic logic [`CRS_IDX_W-1:0] fp_align(
      input logic [`CRS_IDX_W-1:0] a, input logic [1:0] sz);
    case (sz)
      `CRS_FSZ_64: fp_align = {a[4:1], 1'b0};
      `CRS_FSZ_128: fp_align = {a[4:2], 2'b00};
      default: fp_align = a;
    endcase
  endfunction

  function automatic logic lane_on(input logic [1:0] sz, input int k);
    case (sz)
      `CRS_FSZ_64: lane_on = (k < 2);
      `CRS_FSZ_128: lane_on = 1'b1;
      default: lane_on = (k == 0);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Integer file
  // ----------------------------------------------------------------
  logic [`CRS_WORD_W-1:0] int_rda_reg;
  logic [`CRS_WORD_W-1:0] int_rdb_reg;

  // Register zero may hold junk; every read path forces zero instead
  always_ff @(posedge MCLK) begin
    if (CLK_EN && INT_WR.en) begin
      int_mem[INT_WR.addr] <= INT_WR.data;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      int_rda_reg <= '0;
      int_rdb_reg <= '0;
    end else if (CLK_EN) begin
      int_rda_reg <= int_read(INT_RA);
      int_rdb_reg <= int_read(INT_RB);
    end
  end

  // ----------------------------------------------------------------
  // Floating-point file
  // ----------------------------------------------------------------
  wire [`CRS_IDX_W-1:0] fp_rbase = fp_align(FP_RA, FP_RSIZE);
  wire [`CRS_IDX_W-1:0] fp_wbase = fp_align(FP_WR.addr, FP_WR.size);
  logic [`CRS_IDX_W-1:0] fp_ridx [`CRS_NLANE];
  logic [`CRS_IDX_W-1:0] fp_widx [`CRS_NLANE];
  logic [`CRS_WORD_W-1:0] fp_rlane [`CRS_NLANE];
  logic [`CRS_NLANE-1:0] fp_wen;
  logic [`CRS_NLANE*`CRS_WORD_W-1:0] fp_rd_reg;

  genvar k;
  generate
    for (k = 0; k < `CRS_NLANE; k++) begin : g_lane
      assign fp_ridx[k] = fp_rbase + `CRS_IDX_W'(k);
      assign fp_widx[k] = fp_wbase + `CRS_IDX_W'(k);
      assign fp_rlane[k] = lane_on(FP_RSIZE, k) ? fp_read(fp_ridx[k]) : '0;
      assign fp_wen[k] = FP_WR.en && lane_on(FP_WR.size, k);
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    for (int n = 0; n < `CRS_NLANE; n++) begin
      if (CLK_EN && fp_wen[n]) begin
        fp_mem[fp_widx[n]] <= FP_WR.data[n*`CRS_WORD_W +: `CRS_WORD_W];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      fp_rd_reg <= '0;
    end else if (CLK_EN) begin
      fp_rd_reg <= {fp_rlane[3], fp_rlane[2], fp_rlane[1], fp_rlane[0]};
    end
  end

  // ----------------------------------------------------------------
  // Trap causes and control access
  // ----------------------------------------------------------------
  logic [`CRS_WORD_W-1:0] psr_reg;
  logic [`CRS_WORD_W-1:0] psr_next;
  logic [`CRS_WORD_W-1:0] db_reg;

  wire user_mode = psr_reg[`CRS_PSR_U];
  wire ctrl_wr = CTRL.valid && CTRL.write;
  wire ctrl_psr_wr = ctrl_wr && (CTRL.sel == `CRS_CSEL_PSR);
  wire ctrl_db_wr = ctrl_wr && (CTRL.sel == `CRS_CSEL_DB) && !user_mode;
  wire [`CRS_WORD_W-1:0] ctrl_rd_w =
    (CTRL.sel == `CRS_CSEL_PSR) ? psr_reg :
    (CTRL.sel == `CRS_CSEL_DB) ? db_reg : '0;

  wire irq_take = EXT_IRQ && psr_reg[`CRS_PSR_IM];
  // Operand size masks low address bits so overlapping accesses hit
  wire [`CRS_WORD_W-1:0] watch_mask = `CRS_ADDR_ONES << DATA_ACC.size;
  wire addr_hit = ((DATA_ACC.addr ^ db_reg) & watch_mask) == '0;
  wire watch_hit = DATA_ACC.valid && addr_hit &&
    (DATA_ACC.write ? psr_reg[`CRS_PSR_BW] : psr_reg[`CRS_PSR_BR]);
  wire trap_any = TRAP_IN.fp || TRAP_IN.fetch || TRAP_IN.opcode ||
                  irq_take || watch_hit;
  wire flags_any = psr_reg[`CRS_PSR_FT] || psr_reg[`CRS_PSR_DAT] ||
                   psr_reg[`CRS_PSR_IAT] || psr_reg[`CRS_PSR_IN] ||
                   psr_reg[`CRS_PSR_IT];
  wire ret_restore = RET_IND && flags_any;
  wire knf_consume = FP_ISSUE.valid && psr_reg[`CRS_PSR_KNF];

  // ----------------------------------------------------------------
  // Processor state next value
  // ----------------------------------------------------------------
  always_comb begin
    psr_next = psr_reg;
    if (ctrl_psr_wr) begin
      if (user_mode) begin
        psr_next = (psr_reg & ~`CRS_PSR_USER_MASK) |
                   (CTRL.data & `CRS_PSR_USER_MASK);
      end else begin
        psr_next = CTRL.data & `CRS_PSR_RSVD_MASK;
      end
    end
    if (SHR_EV.valid) begin
      psr_next[`CRS_PSR_SC_HI:`CRS_PSR_SC_LO] = SHR_EV.count;
    end
    if (COND_WR.valid) begin
      psr_next[`CRS_PSR_CC] = COND_WR.value;
    end
    if (LOOP_BR.valid) begin
      psr_next[`CRS_PSR_LCC] = LOOP_BR.value;
    end
    if (knf_consume) begin
      psr_next[`CRS_PSR_KNF] = 1'b0;
    end
    if (ret_restore) begin
      psr_next[`CRS_PSR_IM] = psr_reg[`CRS_PSR_PIM];
      psr_next[`CRS_PSR_U] = psr_reg[`CRS_PSR_PU];
    end
    if (trap_any) begin
      psr_next[`CRS_PSR_PIM] = psr_reg[`CRS_PSR_IM];
      psr_next[`CRS_PSR_PU] = psr_reg[`CRS_PSR_PU - 1];
      psr_next[`CRS_PSR_IM] = 1'b0;
      psr_next[`CRS_PSR_U] = 1'b0;
      psr_next[`CRS_PSR_DIM] = TRAP_IN.dual_active;
      psr_next[`CRS_PSR_DS] = TRAP_IN.before_switch;
    end
    // sticky cause flags, set beats clear
    psr_next[`CRS_PSR_FT] = psr_next[`CRS_PSR_FT] | TRAP_IN.fp;
    psr_next[`CRS_PSR_DAT] = psr_next[`CRS_PSR_DAT] | watch_hit;
    psr_next[`CRS_PSR_IAT] = psr_next[`CRS_PSR_IAT] | TRAP_IN.fetch;
    psr_next[`CRS_PSR_IN] = psr_next[`CRS_PSR_IN] | irq_take;
    psr_next[`CRS_PSR_IT] = psr_next[`CRS_PSR_IT] | TRAP_IN.opcode;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      psr_reg <= `CRS_PSR_RST;
      db_reg <= `CRS_DB_RST;
    end else if (CLK_EN) begin
      psr_reg <= psr_next;
      db_reg <= ctrl_db_wr ? CTRL.data : db_reg;
    end
  end

  // ----------------------------------------------------------------
  // Issue mode tracking
  // ----------------------------------------------------------------
  crs_mode_e mode_reg;
  crs_mode_e mode_next;
  logic dual_reg;
  logic dual_next;

  always_comb begin
    mode_next = mode_reg;
    dual_next = dual_reg;
    case (mode_reg)
      MODE_RUN: begin
        if (ret_restore) begin
          dual_next = psr_reg[`CRS_PSR_DIM];
          mode_next = psr_reg[`CRS_PSR_DS] ? MODE_PEND : MODE_RUN;
        end
      end
      MODE_PEND: begin
        if (INSTR_DONE) begin
          dual_next = !psr_reg[`CRS_PSR_DIM];
          mode_next = MODE_RUN;
        end
      end
      default: begin
        mode_next = MODE_RUN;
      end
    endcase
    // Handler always runs single issue
    if (trap_any) begin
      dual_next = 1'b0;
      mode_next = MODE_RUN;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_reg <= MODE_RUN;
      dual_reg <= 1'b0;
    end else if (CLK_EN) begin
      mode_reg <= mode_next;
      dual_reg <= dual_next;
    end
  end

  // ----------------------------------------------------------------
  // Pixel datapath
  // ----------------------------------------------------------------
  logic [63:0] pix_sum_w;
  logic [`CRS_NBYTE-1:0] pst_be_w;

  crs_pixel_unit u_pixel (
    .ps(psr_reg[`CRS_PSR_PS_HI:`CRS_PSR_PS_LO]),
    .pm(psr_reg[`CRS_PSR_PM_HI:`CRS_PSR_PM_LO]),
    .a(PIX_A),
    .b(PIX_B),
    .sum(pix_sum_w),
    .byte_en(pst_be_w)
  );

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [`CRS_WORD_W-1:0] ctrl_rdata_reg;
  logic ctrl_ack_reg;
  logic fp_kill_reg;
  logic fp_dual_reg;
  logic loop_taken_reg;
  logic trap_taken_reg;
  logic [63:0] pix_sum_reg;
  logic [`CRS_NBYTE-1:0] pst_be_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_rdata_reg <= '0;
      ctrl_ack_reg <= 1'b0;
      trap_taken_reg <= 1'b0;
      loop_taken_reg <= 1'b0;
    end else if (CLK_EN) begin
      ctrl_rdata_reg <= CTRL.valid ? ctrl_rd_w : ctrl_rdata_reg;
      ctrl_ack_reg <= CTRL.valid;
      trap_taken_reg <= trap_any;
      loop_taken_reg <= LOOP_BR.valid && psr_reg[`CRS_PSR_LCC];
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      fp_kill_reg <= 1'b0;
      fp_dual_reg <= 1'b0;
      pix_sum_reg <= '0;
      pst_be_reg <= '0;
    end else if (CLK_EN) begin
      fp_kill_reg <= knf_consume;
      fp_dual_reg <= FP_ISSUE.valid ? FP_ISSUE.dual_bit : fp_dual_reg;
      pix_sum_reg <= pix_sum_w;
      pst_be_reg <= pst_be_w;
    end
  end

  assign INT_RDA = int_rda_reg;
  assign INT_RDB = int_rdb_reg;
  assign FP_RD = fp_rd_reg;
  assign CTRL_RDATA = ctrl_rdata_reg;
  assign CTRL_ACK = ctrl_ack_reg;
  assign FP_KILL = fp_kill_reg;
  assign FP_DUAL_BIT = fp_dual_reg;
  assign LOOP_TAKEN = loop_taken_reg;
  assign PIX_SUM = pix_sum_reg;
  assign PST_BYTE_EN = pst_be_reg;
  assign PSR_OUT = psr_reg;
  assign DUAL_MODE = dual_reg;
  assign TRAP_TAKEN = trap_taken_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  a_int_zero_read: assert property (
    CLK_EN && INT_RB == `CRS_ZERO_INT |=> INT_RDB == '0)
    else $error("integer zero register read nonzero");

  a_fp_zero_pair: assert property (
    CLK_EN && FP_RSIZE == `CRS_FSZ_64 && FP_RA <= `CRS_ZERO_FLT_HI
    |=> FP_RD == '0)
    else $error("float zero pair read nonzero");

  a_trap_entry_mode: assert property (
    CLK_EN && trap_any |=> !PSR_OUT[`CRS_PSR_IM] && !PSR_OUT[`CRS_PSR_U]
    && PSR_OUT[`CRS_PSR_PIM] == $past(psr_reg[`CRS_PSR_IM]) && TRAP_TAKEN)
    else $error("trap entry state wrong");

  a_ret_restore: assert property (
    CLK_EN && ret_restore && !trap_any && !ctrl_psr_wr
    |=> PSR_OUT[`CRS_PSR_IM] == $past(psr_reg[`CRS_PSR_PIM])
    && PSR_OUT[`CRS_PSR_U] == $past(psr_reg[`CRS_PSR_PU]))
    else $error("return did not restore saved bits");

  a_irq_masked: assert property (
    CLK_EN && EXT_IRQ && !psr_reg[`CRS_PSR_IM] && !watch_hit
    && !TRAP_IN.fp && !TRAP_IN.fetch && !TRAP_IN.opcode |=> !TRAP_TAKEN)
    else $error("masked interrupt caused a trap");

  a_watch_flag: assert property (
    CLK_EN && watch_hit |=> PSR_OUT[`CRS_PSR_DAT] && TRAP_TAKEN)
    else $error("watch hit not flagged");

  a_knf_kill: assert property (
    CLK_EN && knf_consume |=> FP_KILL
    && FP_DUAL_BIT == $past(FP_ISSUE.dual_bit) && !PSR_OUT[`CRS_PSR_KNF])
    else $error("kill-next not applied");

  a_shift_capture: assert property (
    CLK_EN && SHR_EV.valid |=>
    PSR_OUT[`CRS_PSR_SC_HI:`CRS_PSR_SC_LO] == $past(SHR_EV.count))
    else $error("shift count not captured");

  a_user_psr_guard: assert property (
    CLK_EN && ctrl_psr_wr && user_mode && !trap_any && !ret_restore
    |=> PSR_OUT[`CRS_PSR_IM] == $past(psr_reg[`CRS_PSR_IM])
    && PSR_OUT[`CRS_PSR_U])
    else $error("user write altered protected bits");

  sequence s_ret_deferred;
    CLK_EN && ret_restore && !trap_any && psr_reg[`CRS_PSR_DS]
    && mode_reg == MODE_RUN;
  endsequence

  sequence s_next_instr;
    CLK_EN && INSTR_DONE && !trap_any;
  endsequence

  a_deferred_flip: assert property (
    s_ret_deferred ##1 s_next_instr |=>
    DUAL_MODE == !$past(psr_reg[`CRS_PSR_DIM]))
    else $error("deferred mode switch wrong");

endmodule

// >>> tb/crs_core_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Core-side driver of the control load/store port
// ------------------------------------------------
module crs_core_model (
  input wire logic MCLK,
  output crs_pkg::crs_ctrl_s CTRL,
  input wire logic [31:0] CTRL_RDATA,
  input wire logic CTRL_ACK
);
  import crs_pkg::*;
  initial CTRL = '0;
  task automatic ctrl_op(input logic w, input logic [2:0] s,
    input logic [31:0] d, output logic [31:0] rd, output logic ok);
    // Let one edge pass idle so back-to-back calls never retoggle CTRL
    @(posedge MCLK);
    #1;
    CTRL = '{1'b1, w, s, d};
    @(posedge MCLK);
    #1;
    // Idle lines carry inverted values so a stale copy never passes
    CTRL = '{1'b0, ~w, ~s, ~d};
    rd = CTRL_RDATA;
    ok = CTRL_ACK;
  endtask
endmodule

// >>> tb/crs_regset_tb.sv
`timescale 1ns/1ns
module crs_regset_tb;
  import crs_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
  // ------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------
  logic MCLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, EXT_IRQ = 1'b0;
  logic RET_IND = 1'b0, INSTR_DONE = 1'b0;
  logic [4:0] INT_RA = '0, INT_RB = '0, FP_RA = '0;
  logic [1:0] FP_RSIZE = '0;
  crs_iwr_s INT_WR = '0;
  crs_fwr_s FP_WR = '0;
  crs_ctrl_s CTRL;
  crs_trap_s TRAP_IN = '0;
  crs_dacc_s DATA_ACC = '0;
  crs_fpiss_s FP_ISSUE = '0;
  crs_shr_s SHR_EV = '0;
  crs_flag_s COND_WR = '0, LOOP_BR = '0;
  logic [63:0] PIX_A = '0, PIX_B = '0, PIX_SUM;
  logic [31:0] INT_RDA, INT_RDB, CTRL_RDATA, PSR_OUT, rd;
  logic [127:0] FP_RD;
  logic CTRL_ACK, FP_KILL, FP_DUAL_BIT, LOOP_TAKEN, DUAL_MODE;
  logic TRAP_TAKEN, ok;
  logic [7:0] PST_BYTE_EN;
  logic [7:0] pm_exp [3] = '{8'h35, 8'h33, 8'h0f};
  logic [63:0] pix_exp [3] = '{64'h0, 64'hc0, 64'h0};
  localparam logic [127:0] Q = 128'h44444444_33333333_22222222_11111111;
  int error_cnt = 0, tests_run = 0;

  crs_regset i_crs_regset (.*);
  crs_core_model i_crs_core_model (.*);

  always #5 MCLK = ~MCLK;

  task step;
    @(posedge MCLK);
    #1;
  endtask

  task test_done;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (2000) @(posedge MCLK);
    error_cnt++;
    test_done;
  end

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    repeat (12) @(posedge MCLK);
    #1 RST_B = 1'b1;
    INT_WR = '{1'b1, 5'h00, 32'hdead_beef};
    step;
    INT_WR = '{1'b1, 5'h1f, 32'h1234_5678};
    step;
    INT_WR.en = 1'b0;
    INT_RB = 5'h1f;
    step;
    `CHK("int r0", 32'h0, INT_RDA)
    `CHK("int r31", 32'h1234_5678, INT_RDB)
    FP_WR = '{1'b1, 2'h2, 5'h08, Q};
    step;
    FP_WR = '{1'b1, 2'h1, 5'h00, Q};
    FP_RA = 5'h08;
    FP_RSIZE = 2'h2;
    step;
    FP_WR.en = 1'b0;
    `CHK("fp quad", Q, FP_RD)
    FP_RA = 5'h0b;
    FP_RSIZE = 2'h1;
    step;
    `CHK("fp pair", {64'h0, Q[127:64]}, FP_RD)
    FP_RA = 5'h00;
    step;
    `CHK("fp zero", 128'h0, FP_RD)
    EXT_IRQ = 1'b1;
    SHR_EV = '{1'b1, 5'h13};
    COND_WR = '{1'b1, 1'b1};
    LOOP_BR = '{1'b1, 1'b1};
    step;
    SHR_EV.valid = 1'b0;
    COND_WR.valid = 1'b0;
    LOOP_BR.value = 1'b0;
    `CHK("irq masked", 1'b0, TRAP_TAKEN)
    `CHK("shift", 5'h13, PSR_OUT[21:17])
    `CHK("cond", 1'b1, PSR_OUT[2])
    step;
    LOOP_BR.valid = 1'b0;
    EXT_IRQ = 1'b0;
    `CHK("loop", 1'b1, LOOP_TAKEN)
    `CHK("loop flag", 1'b0, PSR_OUT[3])
    PIX_A = 64'hff;
    PIX_B = 64'h1;
    for (int i = 0; i < 3; i++) begin
      i_crs_core_model.ctrl_op(1'b1, 3'h0, {8'h35, i[1:0], 22'h10}, rd, ok);
      `CHK("ack", 1'b1, ok)
      step;
      `CHK("pix mask", pm_exp[i], PST_BYTE_EN)
      `CHK("pix add", pix_exp[i], PIX_SUM)
    end
    TRAP_IN = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    step;
    TRAP_IN = '0;
    `CHK("trap", 1'b1, TRAP_TAKEN)
    `CHK("trap state", 32'h3580_5020, PSR_OUT)
    `CHK("handler mode", 1'b0, DUAL_MODE)
    RET_IND = 1'b1;
    step;
    RET_IND = 1'b0;
    `CHK("return", 32'h3580_5030, PSR_OUT)
    EXT_IRQ = 1'b1;
    step;
    EXT_IRQ = 1'b0;
    `CHK("irq taken", 32'h3580_1220, PSR_OUT)
    i_crs_core_model.ctrl_op(1'b1, 3'h0, 32'h0000_b000, rd, ok);
    FP_ISSUE = '{1'b1, 1'b1};
    RET_IND = 1'b1;
    step;
    FP_ISSUE = '0;
    RET_IND = 1'b0;
    INSTR_DONE = 1'b1;
    `CHK("fp kill", 1'b1, FP_KILL)
    `CHK("fp dual bit", 1'b1, FP_DUAL_BIT)
    `CHK("kill cleared", 32'h0000_3000, PSR_OUT)
    `CHK("switch pending", 1'b0, DUAL_MODE)
    step;
    INSTR_DONE = 1'b0;
    `CHK("switch done", 1'b1, DUAL_MODE)
    i_crs_core_model.ctrl_op(1'b1, 3'h0, 32'h0000_0040, rd, ok);
    i_crs_core_model.ctrl_op(1'b1, 3'h0, 32'hffff_ffff, rd, ok);
    `CHK("state read", 32'h0000_0040, rd)
    `CHK("user write", 32'hfffe_004c, PSR_OUT)
    i_crs_core_model.ctrl_op(1'b1, 3'h2, 32'h0000_1000, rd, ok);
    i_crs_core_model.ctrl_op(1'b0, 3'h2, 32'h0, rd, ok);
    `CHK("watch addr", 32'h0, rd)
    test_done;
  end
endmodule
